//--- verilog/mfl_defines.svh
// Purpose: Constants of the serial flash read/program engine
// Assumes: 25 MHz system clock
// Notes:   Shared by both ends of the link
`ifndef MFL_DEFINES_SVH
`define MFL_DEFINES_SVH

// Opcodes
`define MFL_OP_DUAL_RD    8'h3B
`define MFL_OP_QUAD_RD    8'h6B
`define MFL_OP_PROG       8'h02

// Timing
`define MFL_CLK_MHZ       25
`define MFL_PAGE_PROG_US  1000
`define MFL_BYTE_PROG_US  10
`define MFL_SCLK_RISE_PH  3'h3
`define MFL_SCLK_FALL_PH  3'h7

// Frame lengths in serial clocks
`define MFL_HDR_BITS_RD   6'h28
`define MFL_HDR_BITS_PG   6'h20
`define MFL_CPB_PROG      4'h8
`define MFL_CPB_DUAL      4'h4
`define MFL_CPB_QUAD      4'h2

// Output enable patterns, low drives
`define MFL_OE_NONE       4'hF
`define MFL_OE_SI         4'hE
`define MFL_OE_DUAL       4'hC
`define MFL_OE_QUAD       4'h0

// Host register offsets and fields
`define MFL_REG_CTRL      4'h0
`define MFL_REG_ADDR      4'h1
`define MFL_REG_LEN       4'h2
`define MFL_REG_DATA      4'h3
`define MFL_REG_STAT      4'h4
`define MFL_CTRL_GO       0
`define MFL_CTRL_OP_LSB   1
`define MFL_CTRL_OP_MSB   2

`endif

//--- verilog/mfl_pkg.sv
// Purpose: Types of the serial flash read/program engine
// Assumes: Constants come from mfl_defines.svh
// Notes:   None
package mfl_pkg;
   typedef logic [3:0]  mfl_raddr_t;
   typedef logic [31:0] mfl_word_t;
   typedef logic [7:0]  mfl_byte_t;
   typedef logic [20:0] mfl_aaddr_t;

   typedef enum logic [2:0] {
      L_CMD   = 3'b000,
      L_ADDR  = 3'b001,
      L_DUMMY = 3'b010,
      L_RDATA = 3'b011,
      L_PDATA = 3'b100,
      L_SKIP  = 3'b101
   } mfl_lstate_t;

   typedef enum logic [2:0] {
      P_IDLE  = 3'b000,
      P_WRITE = 3'b001,
      P_CHECK = 3'b010,
      P_VER   = 3'b011,
      P_WAIT  = 3'b100
   } mfl_pstate_t;

   typedef enum logic [1:0] {
      OP_DUAL = 2'b00,
      OP_QUAD = 2'b01,
      OP_PROG = 2'b10
   } mfl_op_t;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RUN  = 2'b01,
      H_END  = 2'b10
   } mfl_hstate_t;
endpackage : mfl_pkg

//--- verilog/mfl_link_if.sv
// Purpose: Serial flash link between host controller and device
// Assumes: Undriven I/O lines float high
// Notes:   Output enables are active low
`timescale 1ns/1ps
interface mfl_link_if;
   logic       cs_n;
   logic       sclk;
   logic [3:0] h_io;
   logic [3:0] h_oe_n;
   logic [3:0] d_io;
   logic [3:0] d_oe_n;
   wire  [3:0] io;

   // Resolved line level with pull-up
   assign io = (~d_oe_n & d_io) | (~h_oe_n & h_io) | (d_oe_n & h_oe_n);

   modport host (output cs_n, output sclk, output h_io, output h_oe_n, input io);
   modport dev  (input cs_n, input sclk, input io, output d_io, output d_oe_n);
endinterface : mfl_link_if

//--- verilog/mfl_sync.sv
// Purpose: Two-stage synchroniser for link pins
// Assumes: Inputs asynchronous to clock_i
// Notes:   Resets to all ones, the idle level of cs_n and the io lines
`timescale 1ns/1ps
module mfl_sync #(
   parameter int W = 4
) (
   input  wire logic         clock_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         meta <= '1;
         q_o  <= '1;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : mfl_sync

//--- verilog/mfl_dev.sv
// Purpose: Device end: dual/quad output read and page program engine
// Assumes: Link clock at most a quarter of clock_i; array read is combinational
// Notes:   Commands other than the three below are skipped
`timescale 1ns/1ps
`include "mfl_defines.svh"
module mfl_dev #(
   parameter int PAGE_PROG_CYC = `MFL_PAGE_PROG_US * `MFL_CLK_MHZ,
   parameter int BYTE_PROG_CYC = `MFL_BYTE_PROG_US * `MFL_CLK_MHZ
) (
   input  wire logic               clock_i,
   input  wire logic               srst_i,
   mfl_link_if.dev                 link,
   output mfl_pkg::mfl_aaddr_t     arr_addr_o,
   output logic                    arr_wr_o,
   output mfl_pkg::mfl_byte_t      arr_wr_data_o,
   input  wire mfl_pkg::mfl_byte_t arr_rd_data_i,
   input  wire logic [31:0]        sect_prot_i,
   input  wire logic [31:0]        sect_lock_i,
   input  wire logic               write_enable_set_i,
   output logic                    busy_o,
   output logic                    write_enable_latch_o,
   output logic                    prog_err_o
);
   import mfl_pkg::*;

   logic [5:0]  s_pins;
   logic        sclk_d;
   logic        cs_d;
   mfl_lstate_t lstate;
   mfl_pstate_t pstate;
   logic [2:0]  bitcnt;
   logic [1:0]  bytecnt;
   logic [7:0]  sr;
   logic        quad;
   logic        is_prog;
   logic [23:0] addr;
   logic [7:0]  idx;
   logic [7:0]  pbuf [256];
   logic [255:0] vld;
   logic        got_one;
   logic        got_two;
   logic        single;
   logic [7:0]  osr;
   logic [1:0]  ophase;
   logic [8:0]  pidx;
   logic [19:0] timer;

   mfl_sync #(.W(6)) u_sync (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .d_i     ({link.cs_n, link.sclk, link.io}),
      .q_o     (s_pins)
   );

   wire       s_cs_n   = s_pins[5];
   wire       s_sclk   = s_pins[4];
   wire [3:0] s_io     = s_pins[3:0];
   wire       rise     = s_sclk & ~sclk_d & ~s_cs_n;
   wire       fall     = ~s_sclk & sclk_d & ~s_cs_n;
   wire       cs_rise  = s_cs_n & ~cs_d;
   wire [7:0] sh_next  = {sr[6:0], s_io[0]};
   wire       byte_end = (bitcnt == 3'h7);
   wire [1:0] olast    = quad ? 2'h1 : 2'h3;
   wire       prot_hit = sect_prot_i[addr[20:16]] | sect_lock_i[addr[20:16]];
   wire       frame_ok = (lstate == L_PDATA) && (bitcnt == 3'h0) && got_one;
   wire       start_pg = cs_rise & is_prog & frame_ok & ~prot_hit;
   wire       abort_pg = cs_rise & is_prog & ~start_pg;
   wire [19:0] target  = single ? 20'(BYTE_PROG_CYC) : 20'(PAGE_PROG_CYC);
   wire mfl_aaddr_t next_arr_addr = (pstate != P_IDLE) ? {addr[20:8], pidx[7:0]}
                                                        : addr[20:0];
   wire [7:0] cur_byte = pbuf[pidx[7:0]];

   // Edge history
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         sclk_d <= 1'b1;
         cs_d   <= 1'b1;
      end else begin
         sclk_d <= s_sclk;
         cs_d   <= s_cs_n;
      end
   end

   // Link side: command decode, address, read stream, buffer fill
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         lstate     <= L_CMD;
         bitcnt     <= 3'h0;
         bytecnt    <= 2'h0;
         sr         <= 8'h00;
         quad       <= 1'b0;
         is_prog    <= 1'b0;
         addr       <= 24'h000000;
         idx        <= 8'h00;
         vld        <= '0;
         got_one    <= 1'b0;
         got_two    <= 1'b0;
         osr        <= 8'h00;
         ophase     <= 2'h0;
         link.d_io  <= 4'h0;
         link.d_oe_n <= `MFL_OE_NONE;
      end else if (s_cs_n) begin
         lstate      <= L_CMD;
         bitcnt      <= 3'h0;
         bytecnt     <= 2'h0;
         is_prog     <= 1'b0;
         link.d_oe_n <= `MFL_OE_NONE;
      end else if (rise && lstate != L_RDATA) begin
         sr     <= sh_next;
         bitcnt <= bitcnt + 3'h1;
         if (byte_end) begin
            case (lstate)
               L_CMD: begin
                  if (busy_o) begin
                     lstate <= L_SKIP;
                  end else if (sh_next == `MFL_OP_DUAL_RD) begin
                     lstate <= L_ADDR;
                     quad   <= 1'b0;
                  end else if (sh_next == `MFL_OP_QUAD_RD) begin
                     lstate <= L_ADDR;
                     quad   <= 1'b1;
                  end else if (sh_next == `MFL_OP_PROG && write_enable_latch_o) begin
                     lstate  <= L_ADDR;
                     is_prog <= 1'b1;
                     vld     <= '0;
                     got_one <= 1'b0;
                     got_two <= 1'b0;
                  end else begin
                     lstate <= L_SKIP;
                  end
               end
               L_ADDR: begin
                  addr    <= {addr[15:0], sh_next};
                  bytecnt <= bytecnt + 2'h1;
                  if (bytecnt == 2'h2) begin
                     lstate <= is_prog ? L_PDATA : L_DUMMY;
                     idx    <= sh_next;
                  end
               end
               L_DUMMY: begin
                  lstate <= L_RDATA;
                  ophase <= 2'h0;
               end
               L_PDATA: begin
                  pbuf[idx] <= sh_next;
                  vld[idx]  <= 1'b1;
                  idx       <= idx + 8'h01;
                  got_one   <= 1'b1;
                  got_two   <= got_one;
               end
               default: begin
                  lstate <= L_SKIP;
               end
            endcase
         end
      end else if (fall && lstate == L_RDATA) begin
         ophase      <= (ophase == olast) ? 2'h0 : ophase + 2'h1;
         link.d_oe_n <= quad ? `MFL_OE_QUAD : `MFL_OE_DUAL;
         if (ophase == 2'h0) begin
            addr[20:0] <= addr[20:0] + 21'h000001;
            if (quad) begin
               link.d_io <= arr_rd_data_i[7:4];
               osr       <= {arr_rd_data_i[3:0], 4'h0};
            end else begin
               link.d_io <= {2'b00, arr_rd_data_i[7:6]};
               osr       <= {arr_rd_data_i[5:0], 2'b00};
            end
         end else if (quad) begin
            link.d_io <= osr[7:4];
            osr       <= {osr[3:0], 4'h0};
         end else begin
            link.d_io <= {2'b00, osr[7:6]};
            osr       <= {osr[5:0], 2'b00};
         end
      end
   end

   // Program engine and status
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pstate        <= P_IDLE;
         busy_o        <= 1'b0;
         write_enable_latch_o <= 1'b0;
         prog_err_o    <= 1'b0;
         pidx          <= 9'h000;
         timer         <= 20'h00000;
         single        <= 1'b0;
         arr_wr_o      <= 1'b0;
         arr_wr_data_o <= 8'h00;
         arr_addr_o    <= '0;
      end else begin
         arr_wr_o   <= 1'b0;
         arr_addr_o <= next_arr_addr;
         if (write_enable_set_i && !busy_o) begin
            write_enable_latch_o <= 1'b1;
         end
         if (abort_pg || start_pg) begin
            write_enable_latch_o <= 1'b0;
         end
         if (pstate != P_IDLE) begin
            timer <= timer + 20'h00001;
         end
         case (pstate)
            P_IDLE: begin
               if (start_pg) begin
                  busy_o     <= 1'b1;
                  prog_err_o <= 1'b0;
                  pidx       <= 9'h000;
                  timer      <= 20'h00000;
                  single     <= ~got_two;
                  pstate     <= P_WRITE;
               end
            end
            P_WRITE: begin
               if (pidx[8]) begin
                  pstate <= P_WAIT;
               end else if (vld[pidx[7:0]]) begin
                  arr_wr_o      <= 1'b1;
                  arr_wr_data_o <= cur_byte;
                  pstate        <= P_CHECK;
               end else begin
                  pidx <= pidx + 9'h001;
               end
            end
            P_CHECK: begin
               pstate <= P_VER;
            end
            P_VER: begin
               if (arr_rd_data_i != cur_byte) begin
                  prog_err_o <= 1'b1;
               end
               pidx   <= pidx + 9'h001;
               pstate <= P_WRITE;
            end
            P_WAIT: begin
               if (timer >= target) begin
                  busy_o <= 1'b0;
                  pstate <= P_IDLE;
               end
            end
            default: begin
               pstate <= P_IDLE;
            end
         endcase
      end
   end
endmodule : mfl_dev

//--- verilog/mfl_host.sv
// Purpose: Host end: issues dual/quad reads and page programs on the link
// Assumes: Software waits for idle before starting a frame
// Notes:   Serial clock is clock_i divided by eight
`timescale 1ns/1ps
`include "mfl_defines.svh"
module mfl_host (
   input  wire logic               clock_i,
   input  wire logic               srst_i,
   mfl_link_if.host                link,
   input  wire mfl_pkg::mfl_raddr_t reg_addr_i,
   input  wire mfl_pkg::mfl_word_t reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output mfl_pkg::mfl_word_t      reg_rdata_o
);
   import mfl_pkg::*;

   mfl_hstate_t hstate;
   mfl_op_t     op;
   logic [23:0] addr_r;
   logic [8:0]  len_r;
   logic [7:0]  tx_r;
   logic [7:0]  rx_r;
   logic [7:0]  rxb_r;
   logic [2:0]  ph;
   logic [12:0] k;
   logic [3:0]  s_io;

   mfl_sync #(.W(4)) u_sync (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .d_i     (link.io),
      .q_o     (s_io)
   );

   wire        prog    = (op == OP_PROG);
   wire        quad    = (op == OP_QUAD);
   wire [5:0]  hdr     = prog ? `MFL_HDR_BITS_PG : `MFL_HDR_BITS_RD;
   wire [3:0]  cpb     = prog ? `MFL_CPB_PROG : (quad ? `MFL_CPB_QUAD : `MFL_CPB_DUAL);
   wire [12:0] total   = {7'h00, hdr} + ({4'h0, len_r} * {9'h000, cpb});
   wire        in_hdr  = k < {7'h00, hdr};
   wire [12:0] kd      = k - {7'h00, hdr};
   wire [7:0]  opcode  = prog ? `MFL_OP_PROG : (quad ? `MFL_OP_QUAD_RD : `MFL_OP_DUAL_RD);
   wire [39:0] hdr_sr  = {opcode, addr_r, 8'h00};
   wire        hdr_bit = hdr_sr[6'h27 - k[5:0]];
   wire        tx_bit  = tx_r[3'h7 - kd[2:0]];
   wire [7:0]  rx_next = quad ? {rx_r[3:0], s_io} : {rx_r[5:0], s_io[1:0]};
   wire        rx_end  = quad ? kd[0] : (kd[1:0] == 2'h3);
   wire        go      = reg_wr_i && reg_addr_i == `MFL_REG_CTRL
                         && reg_wdata_i[`MFL_CTRL_GO] && hstate == H_IDLE;
   wire        is_stat = reg_addr_i == `MFL_REG_STAT;
   wire        is_data = reg_addr_i == `MFL_REG_DATA;
   wire        is_addr = reg_addr_i == `MFL_REG_ADDR;
   wire        is_len  = reg_addr_i == `MFL_REG_LEN;
   wire mfl_word_t rd_sel = is_stat ? {31'h0, hstate != H_IDLE}
                          : is_data ? {24'h0, rxb_r}
                          : is_addr ? {8'h00, addr_r}
                          : is_len  ? {23'h0, len_r}
                          : 32'h0;

   // Register port
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         addr_r      <= 24'h000000;
         len_r       <= 9'h000;
         tx_r        <= 8'h00;
         reg_rdata_o <= 32'h0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_sel : 32'h0;
         if (reg_wr_i && is_addr) begin
            addr_r <= reg_wdata_i[23:0];
         end
         if (reg_wr_i && is_len) begin
            len_r <= reg_wdata_i[8:0];
         end
         if (reg_wr_i && is_data) begin
            tx_r <= reg_wdata_i[7:0];
         end
      end
   end

   // Frame sequencer
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hstate      <= H_IDLE;
         op          <= OP_DUAL;
         ph          <= 3'h0;
         k           <= 13'h0000;
         rx_r        <= 8'h00;
         rxb_r       <= 8'h00;
         link.cs_n   <= 1'b1;
         link.sclk   <= 1'b0;
         link.h_io   <= 4'h0;
         link.h_oe_n <= `MFL_OE_NONE;
      end else begin
         case (hstate)
            H_IDLE: begin
               if (go) begin
                  op        <= mfl_op_t'(reg_wdata_i[`MFL_CTRL_OP_MSB:`MFL_CTRL_OP_LSB]);
                  ph        <= 3'h0;
                  k         <= 13'h0000;
                  link.cs_n <= 1'b0;
                  hstate    <= H_RUN;
               end
            end
            H_RUN: begin
               ph <= ph + 3'h1;
               if (ph == 3'h0) begin
                  link.h_io   <= {3'b000, in_hdr ? hdr_bit : tx_bit};
                  link.h_oe_n <= (in_hdr || prog) ? `MFL_OE_SI : `MFL_OE_NONE;
               end
               if (ph == `MFL_SCLK_RISE_PH) begin
                  link.sclk <= 1'b1;
               end
               if (ph == `MFL_SCLK_FALL_PH) begin
                  link.sclk <= 1'b0;
                  k         <= k + 13'h0001;
                  if (!in_hdr && !prog) begin
                     rx_r <= rx_next;
                     if (rx_end) begin
                        rxb_r <= rx_next;
                     end
                  end
                  if (k + 13'h0001 == total) begin
                     hstate <= H_END;
                  end
               end
            end
            default: begin
               link.cs_n   <= 1'b1;
               link.h_oe_n <= `MFL_OE_NONE;
               hstate      <= H_IDLE;
            end
         endcase
      end
   end
endmodule : mfl_host

//--- tb/mfl_link_checker.sv
// Purpose: Link checks between the host and device ends
// Assumes: Sees only the link signals, one clock domain
// Notes:   Output enables are low while driving
`timescale 1ns/1ps
module mfl_link_checker (
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic [3:0] h_io,
   input  wire logic [3:0] h_oe_n,
   input  wire logic [3:0] d_io,
   input  wire logic [3:0] d_oe_n,
   input  wire logic [3:0] io
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   a_dev_oe_legal: assert property (d_oe_n inside {4'hF, 4'hC, 4'h0})
      else $error("device enable pattern illegal");
   a_host_oe_si: assert property (h_oe_n inside {4'hF, 4'hE})
      else $error("host drives more than the serial input");
   a_no_contention: assert property ((~d_oe_n & ~h_oe_n) == 4'h0)
      else $error("both ends drive one line");
   a_release_after_cs: assert property ($rose(cs_n) |-> ##[1:6] (d_oe_n == 4'hF))
      else $error("device lines not released after select");
   a_idle_quiet: assert property (cs_n [*8] |-> (d_oe_n == 4'hF) && !sclk)
      else $error("activity outside a frame");
   a_header_no_drive: assert property ($fell(cs_n) |-> (d_oe_n == 4'hF) [*8])
      else $error("device drives during header");
   a_dout_stable: assert property ($rose(sclk) && d_oe_n != 4'hF |-> ##1 $stable(d_io) [*3])
      else $error("read data moves while clock high");
   a_hout_stable: assert property ($rose(sclk) |-> ##1 $stable(h_io) [*3])
      else $error("host data moves while clock high");
   a_sclk_high4: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase wrong");
   a_cs_clk_low: assert property ($rose(cs_n) |-> !sclk)
      else $error("select released with clock high");
   a_resolved_io: assert property ((d_oe_n == 4'h0) |-> (io == d_io))
      else $error("quad lines not carrying device data");
endmodule : mfl_link_checker

//--- tb/multi_io_read_and_page_program_tb.sv
// Purpose: Self-checking bench of host and device ends over the link
// Assumes: Program times shortened by parameters
// Notes:   Array model returns a pattern, writes are logged
`timescale 1ns/1ps
`include "mfl_defines.svh"
module multi_io_read_and_page_program_tb;
   import mfl_pkg::*;
   localparam int PCYC = 1000;
   localparam int BCYC = 40;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   mfl_raddr_t  reg_addr = '0;
   mfl_word_t   reg_wdata = '0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   mfl_word_t   reg_rdata;
   mfl_aaddr_t  arr_addr;
   mfl_aaddr_t  last_a = '0;
   mfl_byte_t   arr_wd;
   mfl_byte_t   arr_rd;
   mfl_byte_t   last_d = '0;
   logic        arr_wr, busy, write_enable_latch, perr;
   logic        last_v = 1'b0;
   logic        bad = 1'b0;
   logic        write_enable_set = 1'b0;
   logic        sclk_q = 1'b0;
   logic [31:0] prot = '0;
   logic [31:0] lock = '0;
   logic [31:0] hdr = '0;
   int          nb = 0;
   int          n_errors = 0;
   int          compares = 0;
   int          busy_len = 0;
   mfl_aaddr_t  wr_a [$];
   mfl_link_if  link ();

   mfl_host u_mfl_host (.clock_i(clock_i), .srst_i(srst_i), .link(link.host),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
   mfl_dev #(.PAGE_PROG_CYC(PCYC), .BYTE_PROG_CYC(BCYC)) u_mfl_dev (.clock_i(clock_i),
      .srst_i(srst_i), .link(link.dev), .arr_addr_o(arr_addr), .arr_wr_o(arr_wr),
      .arr_wr_data_o(arr_wd), .arr_rd_data_i(arr_rd), .sect_prot_i(prot),
      .sect_lock_i(lock), .write_enable_set_i(write_enable_set), .busy_o(busy),
      .write_enable_latch_o(write_enable_latch), .prog_err_o(perr));
   mfl_link_checker u_mfl_link_checker (.clock_i(clock_i), .srst_i(srst_i),
      .cs_n(link.cs_n), .sclk(link.sclk), .h_io(link.h_io), .h_oe_n(link.h_oe_n),
      .d_io(link.d_io), .d_oe_n(link.d_oe_n), .io(link.io));

   function automatic mfl_byte_t pat(input mfl_aaddr_t a);
      return a[7:0] ^ {a[20:16], 3'h5};
   endfunction : pat

   // Array model, bad flips the last written bit 0
   assign arr_rd = (last_v && arr_addr == last_a) ? (last_d ^ {7'h0, bad}) : pat(arr_addr);

   always #20 clock_i = ~clock_i;

   // Header capture and write log
   always @(posedge clock_i) begin
      sclk_q <= link.sclk;
      if (link.cs_n) nb <= 0;
      else if (link.sclk && !sclk_q && nb < 32) begin
         hdr <= {hdr[30:0], link.io[0]};
         nb  <= nb + 1;
      end
      if (arr_wr) begin
         last_a <= arr_addr;
         last_d <= arr_wd;
         last_v <= 1'b1;
         wr_a.push_back(arr_addr);
      end
      if (busy) busy_len <= busy_len + 1;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input mfl_raddr_t a, input mfl_word_t d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock_i);
      reg_wr <= 1'b0;
      @(posedge clock_i);
   endtask : wr

   task automatic rd(input mfl_raddr_t a, output mfl_word_t d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock_i);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clock_i);
   endtask : rd

   task automatic frame(input logic [1:0] op, input mfl_byte_t opc, input mfl_aaddr_t a,
                        input int n);
      mfl_word_t s;
      s = 32'h1;
      wr(`MFL_REG_ADDR, {11'h0, a});
      wr(`MFL_REG_LEN, 32'(n));
      wr(`MFL_REG_DATA, 32'hA5);
      wr(`MFL_REG_CTRL, {29'h0, op, 1'b1});
      for (int i = 0; i < 40000 && s[0] !== 1'b0; i++) rd(`MFL_REG_STAT, s);
      chk("host idle", 32'h0, {31'h0, s[0]});
      chk("header", {opc, 3'h0, a}, hdr);
   endtask : frame

   task automatic rdchk(input logic [1:0] op, input mfl_byte_t opc, input mfl_aaddr_t a,
                        input int n);
      mfl_word_t d;
      frame(op, opc, a, n);
      rd(`MFL_REG_DATA, d);
      chk("read data", {24'h0, pat(a + 21'(n - 1))}, d);
   endtask : rdchk

   task automatic prog(input mfl_aaddr_t a, input int n, input int m, input logic we,
                       input logic e);
      int  cnt;
      logic ok;
      cnt = 0;
      write_enable_set <= we;
      @(posedge clock_i);
      write_enable_set <= 1'b0;
      @(posedge clock_i);
      chk("write enable before", {31'h0, we}, {31'h0, write_enable_latch});
      wr_a.delete();
      busy_len = 0;
      frame(2'd2, `MFL_OP_PROG, a, n);
      repeat (8) @(posedge clock_i);
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clock_i);
      foreach (wr_a[k]) cnt += (wr_a[k][20:8] == a[20:8] && 8'(wr_a[k][7:0] - a[7:0]) < m);
      ok = (m == 0) ? busy_len == 0 : (m == 1) ? (busy_len >= BCYC && busy_len < PCYC) :
           busy_len >= PCYC;
      chk("writes", m, wr_a.size());
      chk("in page", m, cnt);
      chk("busy time", 32'h1, {31'h0, ok});
      chk("write enable after", 32'h0, {31'h0, write_enable_latch});
      chk("prog err", {31'h0, e}, {31'h0, perr});
      if (m > 0) chk("prog data", 32'hA5, {24'h0, last_d});
   endtask : prog

   task automatic print_verdict();
      $display("Comparisons %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (6) @(posedge clock_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk("busy reset", 32'h0, {31'h0, busy});
      rdchk(2'd0, `MFL_OP_DUAL_RD, 21'h012345, 1);
      rdchk(2'd0, `MFL_OP_DUAL_RD, 21'h1FFFFE, 4);
      rdchk(2'd1, `MFL_OP_QUAD_RD, 21'h0ABCDE, 2);
      rdchk(2'd1, `MFL_OP_QUAD_RD, 21'h1FFFFF, 3);
      prog(21'h0000FE, 3, 3, 1'b1, 1'b0);
      prog(21'h003310, 1, 1, 1'b1, 1'b0);
      prog(21'h004020, 258, 256, 1'b1, 1'b0);
      prog(21'h005000, 0, 0, 1'b1, 1'b0);
      prog(21'h006000, 1, 0, 1'b0, 1'b0);
      prot <= 32'h2;
      lock <= 32'h4;
      prog(21'h012000, 2, 0, 1'b1, 1'b0);
      prog(21'h020000, 2, 0, 1'b1, 1'b0);
      bad <= 1'b1;
      prog(21'h007000, 1, 1, 1'b1, 1'b1);
      bad <= 1'b0;
      prog(21'h007100, 1, 1, 1'b1, 1'b0);
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge clock_i);
      n_errors++;
      print_verdict();
   end
endmodule : multi_io_read_and_page_program_tb
